/* File: ccss_osc_model.sv */
// Purpose: oscillator side model feeding the start-up sequencer
// Assumes: osc and watchdog ticks are one-cycle pulses on aclk; async_tick toggles every four cycles
// Notes:   slow mode spaces oscillator ticks at random
module ccss_osc_model (
  // clock and pacing
  input  wire logic aclk,
  input  wire logic slow,
  // oscillator ticks
  output logic      osc_tick,
  output logic      wdog_tick,
  output logic      async_tick
);
  timeunit 1ns;
  timeprecision 1ns;
  int gap_o = 0;
  int gap_w = 0;
  int gap_a = 0;
  initial
  begin
    osc_tick = 1'b0;
    wdog_tick = 1'b0;
    async_tick = 1'b0;
  end
  always @(posedge aclk)
  begin
    // one pulse per oscillator cycle, never two in a row
    osc_tick <= (gap_o == 0);
    gap_o <= (gap_o == 0) ? (slow ? 1 + $urandom % 3 : 1) : gap_o - 1;
    // watchdog oscillator ticks every third cycle, slower than the main one while slow is low
    wdog_tick <= (gap_w == 0);
    gap_w <= (gap_w == 0) ? 2 : gap_w - 1;
    // timer crystal runs free, sleep or not
    if (gap_a == 0)
      async_tick <= !async_tick;
    gap_a <= (gap_a == 0) ? 3 : gap_a - 1;
  end
endmodule

/* File: ccss_pkg.sv */
// Purpose: shared constants for the clock source start-up sequencer
// Assumes: fuse levels are static inputs, 1 = unprogrammed, 0 = programmed
// Notes:   oscillator counts above 4096 live as top-level parameters
package ccss_pkg;

  // clock source classes after fuse decode
  typedef enum logic [2:0] {
    CCSS_SRC_EXT  = 3'h0,
    CCSS_SRC_RC   = 3'h1,
    CCSS_SRC_R128 = 3'h2,
    CCSS_SRC_LFX  = 3'h3,
    CCSS_SRC_LPX  = 3'h4
  } ccss_src_e;

  // watchdog time-out choice
  localparam logic [1:0] CCSS_WD_NONE  = 2'h0;
  localparam logic [1:0] CCSS_WD_SHORT = 2'h1;
  localparam logic [1:0] CCSS_WD_LONG  = 2'h2;

  // fuse encodings
  localparam logic [3:0] CCSS_CLOCK_SOURCE_SELECT_FUSES_EXT  = 4'h0;
  localparam logic [3:0] CCSS_CLOCK_SOURCE_SELECT_FUSES_RC   = 4'h2;
  localparam logic [3:0] CCSS_CLOCK_SOURCE_SELECT_FUSES_R128 = 4'h3;
  localparam logic [2:0] CCSS_CLOCK_SOURCE_SELECT_FUSES_LFX  = 3'h2;
  localparam logic [1:0] CCSS_SUT_RSVD   = 2'h3;
  localparam logic [1:0] CCSS_SUT_SAFE   = 2'h2;

  // factory default fuse image
  localparam logic [3:0] CCSS_DFLT_CLOCK_SOURCE_SELECT_FUSES = 4'h2;
  localparam logic [1:0] CCSS_DFLT_SUT   = 2'h2;
  localparam logic       CCSS_DFLT_DIV8  = 1'h0;

  // cycle counts that fit below the parameter threshold
  localparam logic [15:0] CCSS_WD_SHORT_CYC = 16'h0200;
  localparam logic [15:0] CCSS_OSC_EXT_CYC  = 16'h0006;
  localparam logic [15:0] CCSS_OSC_258_CYC  = 16'h0102;
  localparam logic [15:0] CCSS_OSC_1K_CYC   = 16'h0400;
  localparam logic [15:0] CCSS_RST_EXTRA    = 16'h0013;
  localparam logic [2:0]  CCSS_DIV8_LAST    = 3'h7;

  // register map and fields
  localparam logic [3:0] CCSS_OFS_CTRL   = 4'h0;
  localparam logic [3:0] CCSS_OFS_STATUS = 4'h4;
  localparam logic [3:0] CCSS_OFS_CFG    = 4'h8;
  localparam int CCSS_CTRL_SLEEP_BIT = 0;
  localparam int CCSS_CTRL_CONV_BIT  = 1;
  localparam logic [1:0] CCSS_RESP_OKAY   = 2'h0;
  localparam logic [1:0] CCSS_RESP_SLVERR = 2'h2;

endpackage

/* File: ccss_sequencer.sv */
// Purpose: clock source decode and start-up/reset sequencing
// Assumes: oscillator and watchdog cycles arrive as aclk-synchronous ticks
// Notes:   registers reached over AXI4-Lite, one word per register
//
// Chosen here: the address map and the AXI4-Lite register port.

// Notes on behaviour
// RQ1: fuse bit 1 unprogrammed, 0 programmed
// RQ2: select 1xxx low-power, 010x low-frequency crystal
// RQ3: 0011 128k, 0010 RC, 0000 external
// RQ4: factory default RC, start code 10, divided
// RQ5: extra internal reset after other sources release
// RQ6: time-out counted in 0, 512 or 8192 cycles
// RQ7: oscillator count holds reset until done
// RQ8: wake uses oscillator count only, no time-out
// RQ9: start count by clock type, 6 to 32K
// RQ10: upper select bits give crystal frequency range
// RQ11: low-power bit0=0, codes 00/01: 258 cycles
// RQ12: resonator settings use 1K-cycle start-up
// RQ13: crystal bit0=1 uses 16K-cycle start-up
// RQ14: programmed divider divides clock by eight
// RQ15: async timer domain keeps running in sleep
// RQ16: converter clock may run while core halted
// RQ17: internal RC wakes in 6 cycles
// RQ18: fuses sampled once; reserved codes made safe
// RQ19: release synchronised before core reset lifts
module ccss_sequencer #(
  parameter int unsigned WD_LONG_CYC = 8192,
  parameter int unsigned OSC_16K_CYC = 16384,
  parameter int unsigned OSC_32K_CYC = 32768
) (
  // clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // fuses and tick sources
  input  wire logic [3:0]            clock_source_select_fuses,
  input  wire logic [1:0]            startup_time_fuses,
  input  wire logic                  divide_by_eight_fuse,
  input  wire logic                  osc_tick,
  input  wire logic                  wdog_tick,
  input  wire logic                  async_tick,
  input  wire logic                  ext_reset_req,
  input  wire logic                  wake_req,
  // clock and reset outputs
  output logic                       core_reset_n_r,
  output logic                       cpu_clk_en_r,
  output logic                       sys_clk_en_r,
  output logic                       converter_clk_en_r,
  output logic                       async_timer_clock_r,
  output ccss_pkg::ccss_src_e        selected_source_r,
  // axi4-lite write
  input  wire logic [3:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  // axi4-lite read
  input  wire logic [3:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready
);

  import ccss_pkg::*;

  // counts must fit the 16-bit tick counters, extra cycles included
  if (WD_LONG_CYC < 2 || WD_LONG_CYC > 65535)
  begin : g_wd_chk
    $error("ccss_sequencer: WD_LONG_CYC out of range");
  end
  if (OSC_16K_CYC < 2 || OSC_32K_CYC + 19 > 65535)
  begin : g_osc_chk
    $error("ccss_sequencer: oscillator counts out of range");
  end

  typedef enum logic [6:0] {
    S_LOAD  = 7'h01,
    S_HOLD  = 7'h02,
    S_TOUT  = 7'h04,
    S_OSC   = 7'h08,
    S_SYNC  = 7'h10,
    S_RUN   = 7'h20,
    S_SLEEP = 7'h40
  } ccss_state_e;

  localparam logic [15:0] WD_LONG  = 16'(WD_LONG_CYC);
  localparam logic [15:0] OSC_16K  = 16'(OSC_16K_CYC);
  localparam logic [15:0] OSC_32K  = 16'(OSC_32K_CYC);

  ccss_state_e st_r;
  ccss_state_e st_nxt;

  logic [3:0] clock_source_select_fuses_r;
  logic [1:0] sut_r;
  logic       div8_fuse_r;
  logic       fuses_taken_r;
  logic       from_sleep_r;
  logic       conv_keep_r;
  logic       rel_req_r;
  logic       rel_s1_r;
  logic       rel_s2_r;
  logic [2:0] div_cnt_r;
  logic       wd_done;
  logic       osc_done;

  // fuse decode
  // RQ1: zero means programmed
  wire div8_en = (div8_fuse_r == 1'h0);
  // RQ2: crystal classes
  wire is_lpx = clock_source_select_fuses_r[3];
  wire is_lfx = (clock_source_select_fuses_r[3:1] == CCSS_CLOCK_SOURCE_SELECT_FUSES_LFX);
  // RQ3: single-code sources
  wire is_r128 = (clock_source_select_fuses_r == CCSS_CLOCK_SOURCE_SELECT_FUSES_R128);
  wire is_ext  = (clock_source_select_fuses_r == CCSS_CLOCK_SOURCE_SELECT_FUSES_EXT);
  // RQ18: reserved source codes fall back to internal rc
  ccss_src_e src;
  assign src = is_lpx  ? CCSS_SRC_LPX  :
               is_lfx  ? CCSS_SRC_LFX  :
               is_r128 ? CCSS_SRC_R128 :
               is_ext  ? CCSS_SRC_EXT  : CCSS_SRC_RC;
  // RQ18: reserved start code picks the longest safe delay
  wire [1:0] sut_eff = (!is_lpx && sut_r == CCSS_SUT_RSVD) ?
                       CCSS_SUT_SAFE : sut_r;
  // RQ10: frequency range is select bits 2:1 in low-power mode
  wire [1:0] lp_range = is_lpx ? clock_source_select_fuses_r[2:1] : 2'h0;

  // RQ6: time-out selection
  wire [2:0] lp_key = {clock_source_select_fuses_r[0], sut_r};
  logic [1:0] wd_sel;
  always_comb
  begin
    wd_sel = CCSS_WD_NONE;
    if (is_lpx)
      unique case (lp_key)
        3'h0, 3'h3, 3'h6: wd_sel = CCSS_WD_SHORT;
        3'h1, 3'h4, 3'h7: wd_sel = CCSS_WD_LONG;
        3'h2, 3'h5:       wd_sel = CCSS_WD_NONE;
      endcase
    else
      unique case (sut_eff)
        2'h0: wd_sel = CCSS_WD_NONE;
        2'h1: wd_sel = CCSS_WD_SHORT;
        2'h2, 2'h3: wd_sel = CCSS_WD_LONG;
      endcase
  end
  wire [15:0] wd_target = (wd_sel == CCSS_WD_LONG)  ? WD_LONG :
                          (wd_sel == CCSS_WD_SHORT) ? CCSS_WD_SHORT_CYC :
                          16'h0000;

  // RQ9: start-up count by clock type
  // RQ11: low-power, resonator short start
  // RQ12: resonator 1K start
  // RQ13: crystal 16K start
  // RQ17: internal sources and external clock use 6
  wire [15:0] lp_start = !clock_source_select_fuses_r[0] ?
                         (sut_r[1] ? CCSS_OSC_1K_CYC : CCSS_OSC_258_CYC) :
                         ((sut_r == 2'h0) ? CCSS_OSC_1K_CYC : OSC_16K);
  wire [15:0] start_cyc = is_lpx ? lp_start :
                          is_lfx ? (clock_source_select_fuses_r[0] ? OSC_32K : CCSS_OSC_1K_CYC) :
                          CCSS_OSC_EXT_CYC;
  // RQ8: reset path adds the extra cycles, wake path does not
  wire [15:0] osc_target = from_sleep_r ? start_cyc :
                           16'(start_cyc + CCSS_RST_EXTRA);

  // axi decode
  logic        aw_held_r;
  logic        w_held_r;
  logic [3:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  wire aw_hs = s_axi_awvalid && s_axi_awready;
  wire w_hs  = s_axi_wvalid && s_axi_wready;
  wire ar_hs = s_axi_arvalid && s_axi_arready;
  wire b_hs  = s_axi_bvalid && s_axi_bready;
  wire r_hs  = s_axi_rvalid && s_axi_rready;
  wire do_wr = aw_held_r && w_held_r && !s_axi_bvalid;
  wire wr_ctrl = do_wr && (awaddr_r == CCSS_OFS_CTRL) && wstrb_r[0];
  wire wr_ok = (awaddr_r == CCSS_OFS_CTRL) ||
               (awaddr_r == CCSS_OFS_STATUS) ||
               (awaddr_r == CCSS_OFS_CFG);
  wire sleep_cmd = wr_ctrl && wdata_r[CCSS_CTRL_SLEEP_BIT];
  wire [31:0] status_word = {5'h00, lp_range, div8_fuse_r,
                             clock_source_select_fuses_r, 2'h0, sut_r, 3'h0, fuses_taken_r,
                             1'h0, src, 1'h0, st_r};
  wire [31:0] cfg_word = {wd_target, osc_target};
  wire [31:0] rd_word  = (s_axi_araddr == CCSS_OFS_CTRL) ?
                         {30'h0, conv_keep_r, 1'h0} :
                         (s_axi_araddr == CCSS_OFS_STATUS) ? status_word :
                         (s_axi_araddr == CCSS_OFS_CFG) ? cfg_word : 32'h0;
  wire rd_ok = (s_axi_araddr == CCSS_OFS_CTRL) ||
               (s_axi_araddr == CCSS_OFS_STATUS) ||
               (s_axi_araddr == CCSS_OFS_CFG);

  // sequencing
  always_comb
  begin
    st_nxt = st_r;
    unique case (st_r)
      S_LOAD:  if (fuses_taken_r) st_nxt = S_HOLD;
      S_HOLD:  if (!ext_reset_req) st_nxt = S_TOUT;
      S_TOUT:  if (wd_done) st_nxt = S_OSC;
      S_OSC:   if (osc_done) st_nxt = S_SYNC;
      S_SYNC:  if (rel_s2_r) st_nxt = S_RUN;
      S_RUN:   if (sleep_cmd) st_nxt = S_SLEEP;
      S_SLEEP: if (wake_req) st_nxt = S_OSC;
      default: st_nxt = S_LOAD;
    endcase
    // RQ5: any other reset source restarts the sequence
    if (ext_reset_req && st_r != S_LOAD)
      st_nxt = S_HOLD;
  end

  wire start_wd  = (st_nxt == S_TOUT) && (st_r != S_TOUT);
  wire start_osc = (st_nxt == S_OSC) && (st_r != S_OSC);
  // RQ14: one system pulse per eight oscillator cycles when divided
  wire sys_pulse = osc_tick && (!div8_en || div_cnt_r == CCSS_DIV8_LAST);
  wire core_up_nxt = (st_nxt == S_RUN) || (st_nxt == S_SLEEP);

  // RQ6: watchdog cycle time-out
  ccss_tick_counter #(.W(16)) u_wd_cnt (
    .aclk    (aclk),
    .aresetn (aresetn),
    .start   (start_wd),
    .tick    (wdog_tick),
    .target  (wd_target),
    .done_r  (wd_done)
  );

  // RQ7: oscillator ripple count
  ccss_tick_counter #(.W(16)) u_osc_cnt (
    .aclk    (aclk),
    .aresetn (aresetn),
    .start   (start_osc),
    .tick    (osc_tick),
    .target  (osc_target),
    .done_r  (osc_done)
  );

  // RQ4: sampled fuses start from the factory image
  // RQ18: captured once after power-on reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      clock_source_select_fuses_r       <= CCSS_DFLT_CLOCK_SOURCE_SELECT_FUSES;
      sut_r         <= CCSS_DFLT_SUT;
      div8_fuse_r   <= CCSS_DFLT_DIV8;
      fuses_taken_r <= 1'b0;
    end
    else if (!fuses_taken_r)
    begin
      clock_source_select_fuses_r       <= clock_source_select_fuses;
      sut_r         <= startup_time_fuses;
      div8_fuse_r   <= divide_by_eight_fuse;
      fuses_taken_r <= 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_r         <= S_LOAD;
      from_sleep_r <= 1'b0;
      div_cnt_r    <= 3'h0;
    end
    else
    begin
      st_r <= st_nxt;
      if (start_osc)
        from_sleep_r <= (st_r == S_SLEEP);
      if (osc_tick)
        div_cnt_r <= div_cnt_r + 3'h1;
    end
  end

  // RQ19: release crosses two flops before core reset lifts
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rel_req_r <= 1'b0;
      rel_s1_r  <= 1'b0;
      rel_s2_r  <= 1'b0;
    end
    else
    begin
      rel_req_r <= (st_nxt == S_SYNC);
      rel_s1_r  <= rel_req_r;
      rel_s2_r  <= rel_s1_r;
    end
  end

  // clock enables; sleep halts the core, and the converter unless conv_keep_r is set
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      core_reset_n_r      <= 1'b0;
      cpu_clk_en_r        <= 1'b0;
      sys_clk_en_r        <= 1'b0;
      converter_clk_en_r  <= 1'b0;
      async_timer_clock_r <= 1'b0;
      selected_source_r   <= CCSS_SRC_RC;
    end
    else
    begin
      core_reset_n_r      <= core_up_nxt;
      cpu_clk_en_r        <= sys_pulse && (st_nxt == S_RUN);
      sys_clk_en_r        <= sys_pulse;
      // RQ16: converter may keep running in sleep
      converter_clk_en_r  <= sys_pulse && ((st_nxt == S_RUN) ||
                             ((st_nxt == S_SLEEP) && conv_keep_r));
      // RQ15: timer domain ignores sleep and reset sequencing
      async_timer_clock_r <= async_tick;
      selected_source_r   <= src;
    end
  end

  // axi4-lite slave: one write and one read in flight
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_r     <= 1'b0;
      w_held_r      <= 1'b0;
      awaddr_r      <= 4'h0;
      wdata_r       <= 32'h0;
      wstrb_r       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= CCSS_RESP_OKAY;
      conv_keep_r   <= 1'b0;
    end
    else
    begin
      if (aw_hs)
      begin
        aw_held_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      if (w_hs)
      begin
        w_held_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      s_axi_awready <= !aw_held_r && !aw_hs && !s_axi_bvalid;
      s_axi_wready  <= !w_held_r && !w_hs && !s_axi_bvalid;
      if (do_wr)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? CCSS_RESP_OKAY : CCSS_RESP_SLVERR;
        aw_held_r    <= 1'b0;
        w_held_r     <= 1'b0;
      end
      else if (b_hs)
        s_axi_bvalid <= 1'b0;
      if (wr_ctrl)
        conv_keep_r <= wdata_r[CCSS_CTRL_CONV_BIT];
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= CCSS_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !ar_hs && !s_axi_rvalid;
      if (ar_hs)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_ok ? CCSS_RESP_OKAY : CCSS_RESP_SLVERR;
      end
      else if (r_hs)
        s_axi_rvalid <= 1'b0;
    end
  end

  // checks
  hold_reset_a: assert property (@(posedge aclk) disable iff (!aresetn) // RQ5
    (ext_reset_req && fuses_taken_r) |=> !core_reset_n_r ##1 !core_reset_n_r)
    else $error("core left reset while another source held it");

  fuse_stable_a: assert property (@(posedge aclk) disable iff (!aresetn) // RQ18
    fuses_taken_r |=> $stable(clock_source_select_fuses_r) && $stable(sut_r))
    else $error("sampled fuses changed after capture");

  div_rate_a: assert property (@(posedge aclk) disable iff (!aresetn) // RQ14
    (sys_clk_en_r && div8_en) |=> !sys_clk_en_r [*7])
    else $error("divided system pulse came early");

  wake_path_a: assert property (@(posedge aclk) disable iff (!aresetn) // RQ8
    (st_r == S_SLEEP && wake_req && !ext_reset_req) |=>
    (st_r == S_OSC) && from_sleep_r && (osc_target == start_cyc))
    else $error("wake did not go straight to oscillator count");

  osc_hold_a: assert property (@(posedge aclk) disable iff (!aresetn) // RQ7
    (st_r == S_OSC && !osc_done) |=> !core_reset_n_r)
    else $error("core released before oscillator count done");

  sync_rel_a: assert property (@(posedge aclk) disable iff (!aresetn) // RQ19
    $rose(core_reset_n_r) && !from_sleep_r |-> $past(rel_s2_r, 1))
    else $error("core reset lifted without synchronised release");

  lp_map_a: assert property (@(posedge aclk) disable iff (!aresetn) // RQ2
    (fuses_taken_r && clock_source_select_fuses_r[3]) |=> selected_source_r == CCSS_SRC_LPX)
    else $error("low-power crystal not selected");

  rsvd_map_a: assert property (@(posedge aclk) disable iff (!aresetn) // RQ3
    (clock_source_select_fuses_r == 4'h1 || clock_source_select_fuses_r == CCSS_CLOCK_SOURCE_SELECT_FUSES_RC) |=>
    selected_source_r == CCSS_SRC_RC)
    else $error("rc or reserved code not mapped to rc");

  sleep_halt_a: assert property (@(posedge aclk) disable iff (!aresetn) // RQ16
    (st_nxt == S_SLEEP) |=> !cpu_clk_en_r && core_reset_n_r)
    else $error("cpu clock ran during sleep");

endmodule

/* File: ccss_tick_counter.sv */
// Purpose: counts enable ticks up to a target after a start pulse
// Assumes: target stays stable while busy
// Notes:   done is a level held until the next start
module ccss_tick_counter #(
  parameter int W = 16
) (
  // clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // control
  input  wire logic         start,
  input  wire logic         tick,
  input  wire logic [W-1:0] target,
  output logic              done_r
);

  if (W < 2)
  begin : g_w_chk
    $error("ccss_tick_counter: W too small");
  end

  logic [W-1:0] cnt_r;
  logic         busy_r;
  wire          hit = busy_r && (cnt_r == target);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_r  <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end
    else if (start)
    begin
      cnt_r  <= '0;
      busy_r <= 1'b1;
      done_r <= 1'b0;
    end
    else if (hit)
    begin
      busy_r <= 1'b0;
      done_r <= 1'b1;
    end
    else if (busy_r && tick)
      cnt_r <= cnt_r + 1'b1;
  end

endmodule

/* File: tb.sv */
// Purpose: self-checking bench for the start-up sequencer
// Assumes: long counts shortened through parameters
// Notes:   bus results are checked by a monitor from a note queue
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ccss_pkg::*;
  typedef struct {
    logic [3:0]  ck;
    logic [1:0]  su;
    logic [2:0]  src;
    logic [15:0] osc;
    logic [15:0] wd;
  } ccss_case_s;
  ccss_case_s  tbl [12] = '{
    '{4'h0, 2'h0, 3'h0, 16'h0019, 16'h0000},
    '{4'h2, 2'h0, 3'h1, 16'h0019, 16'h0000},
    '{4'h3, 2'h1, 3'h2, 16'h0019, 16'h0200},
    '{4'h5, 2'h2, 3'h3, 16'h003B, 16'h0014},
    '{4'h4, 2'h0, 3'h3, 16'h0413, 16'h0000},
    '{4'h8, 2'h0, 3'h4, 16'h0115, 16'h0200},
    '{4'h8, 2'h1, 3'h4, 16'h0115, 16'h0014},
    '{4'hA, 2'h2, 3'h4, 16'h0413, 16'h0000},
    '{4'hD, 2'h0, 3'h4, 16'h0413, 16'h0014},
    '{4'hF, 2'h1, 3'h4, 16'h0031, 16'h0000},
    '{4'hB, 2'h3, 3'h4, 16'h0031, 16'h0014},
    '{4'h1, 2'h2, 3'h1, 16'h0019, 16'h0014}};
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [3:0]  ck_f = 4'h2;
  logic [1:0]  su_f = 2'h2;
  logic        div_f = 1'b0;
  logic        slow = 1'b0;
  logic        ext_req = 1'b1;
  logic        wake = 1'b0;
  logic        osc_tick, wdog_tick, async_tick;
  logic        rst_n, cpu_en, sys_en, conv_en, asy_clk;
  ccss_src_e   src;
  logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [33:0] notes [$];
  logic [31:0] masks [$];
  logic [33:0] seen_v;
  int          n_mismatch = 0;
  int          tests_run = 0;
  int          cyc = 0;
  int          cnt_o = 0;
  int          cnt_w = 0;

  always #10 aclk = ~aclk;

  ccss_sequencer #(
    .WD_LONG_CYC (20),
    .OSC_16K_CYC (30),
    .OSC_32K_CYC (40)
  ) dut (
    .aclk(aclk), .aresetn(aresetn),
    .clock_source_select_fuses(ck_f), .startup_time_fuses(su_f),
    .divide_by_eight_fuse(div_f), .osc_tick(osc_tick),
    .wdog_tick(wdog_tick), .async_tick(async_tick),
    .ext_reset_req(ext_req), .wake_req(wake),
    .core_reset_n_r(rst_n), .cpu_clk_en_r(cpu_en), .sys_clk_en_r(sys_en),
    .converter_clk_en_r(conv_en), .async_timer_clock_r(asy_clk),
    .selected_source_r(src),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready)
  );

  ccss_osc_model osc (
    .aclk(aclk), .slow(slow), .osc_tick(osc_tick),
    .wdog_tick(wdog_tick), .async_tick(async_tick)
  );

  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
                        input logic [1:0] resp);
    notes.push_back({resp, 32'h0});
    masks.push_back(32'h0);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [3:0] a, input logic [31:0] e,
                        input logic [31:0] m, input logic [1:0] resp);
    notes.push_back({resp, e & m});
    masks.push_back(m);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask

  task automatic do_reset(input logic [3:0] c, input logic [1:0] s,
                          input logic d);
    @(posedge aclk);
    aresetn <= 1'b0;
    ck_f <= c;
    su_f <= s;
    div_f <= d;
    ext_req <= 1'b1;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
  endtask

  // ticks seen while the core is held, counted once other sources let go
  always @(posedge aclk)
  begin
    cyc++;
    if (ext_req)
    begin
      cnt_o <= 0;
      cnt_w <= 0;
    end
    else if (rst_n === 1'b0)
    begin
      cnt_o <= cnt_o + osc_tick;
      cnt_w <= cnt_w + wdog_tick;
    end
    if ((rvalid && rready) || (bvalid && bready))
    begin
      seen_v = rvalid ? {rresp, rdata & masks.pop_front()} : {bresp, 32'h0};
      if (bvalid)
        void'(masks.pop_front());
      check(seen_v, notes.pop_front());
    end
    if (cyc == 80000)
    begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  initial
  begin
    ccss_case_s  t;
    logic [31:0] e;
    logic [31:0] m;
    int          no;
    int          ns;
    int          nc;
    int          na;
    logic        aq;
    void'($urandom(32'hE157));
    for (int i = 0; i < 12; i++)
    begin
      t = tbl[i];
      slow <= i[0];
      do_reset(t.ck, t.su, i[1]);
      repeat (10) @(posedge aclk);
      check(rst_n, 1'b0);
      ext_req <= 1'b0;
      e = {7'h0, i[1], t.ck, 2'h0, t.su, 3'h0, 1'b1, 1'b0, t.src, 8'h0};
      m = 32'h01F3_1700;
      // lp crystal reports its frequency range
      if (t.src == 3'h4)
      begin
        e = e | {5'h0, t.ck[2:1], 25'h0};
        m = m | 32'h0600_0000;
      end
      axi_rd(CCSS_OFS_STATUS, e, m, CCSS_RESP_OKAY);
      axi_rd(CCSS_OFS_CFG, {t.wd, t.osc}, 32'hFFFF_FFFF, CCSS_RESP_OKAY);
      while (rst_n !== 1'b1)
        @(posedge aclk);
      check(cnt_w >= t.wd, 1'b1);
      check(cnt_o >= t.osc, 1'b1);
      check(src, t.src);
      no = 0;
      ns = 0;
      repeat (200)
      begin
        @(posedge aclk);
        no += osc_tick;
        ns += sys_en;
      end
      check(((i[1] ? no : no / 8) - ns) inside {-1, 0, 1}, 1'b1);
    end
    do_reset(CCSS_DFLT_CLOCK_SOURCE_SELECT_FUSES, CCSS_DFLT_SUT, CCSS_DFLT_DIV8);
    ext_req <= 1'b0;
    while (rst_n !== 1'b1)
      @(posedge aclk);
    check(src, CCSS_SRC_RC);
    axi_wr(CCSS_OFS_CTRL, 32'h2, CCSS_RESP_OKAY);
    axi_rd(CCSS_OFS_CTRL, 32'h2, 32'h3, CCSS_RESP_OKAY);
    // random data must not disturb the read-only status word
    axi_wr(CCSS_OFS_STATUS, $urandom, CCSS_RESP_OKAY);
    axi_rd(CCSS_OFS_STATUS, 32'h221120, 32'h01F3_177F, CCSS_RESP_OKAY);
    axi_rd(4'hC, 32'h0, 32'hFFFF_FFFF, CCSS_RESP_SLVERR);
    axi_wr(CCSS_OFS_CTRL, 32'h3, CCSS_RESP_OKAY);
    repeat (4) @(posedge aclk);
    nc = 0;
    ns = 0;
    na = 0;
    aq = asy_clk;
    repeat (100)
    begin
      @(posedge aclk);
      nc += cpu_en;
      ns += conv_en;
      na += (asy_clk !== aq);
      aq = asy_clk;
    end
    check(nc, 0);
    check(ns > 0, 1'b1);
    check(na > 0, 1'b1);
    wake <= 1'b1;
    @(posedge aclk);
    wake <= 1'b0;
    no = 0;
    while (cpu_en !== 1'b1)
    begin
      @(posedge aclk);
      no += osc_tick;
    end
    // wake skips the 19-cycle extra and the time-out, divided by eight
    check(no >= 6 && no < 25, 1'b1);
    check(rst_n, 1'b1);
    tally_and_finish();
  end
endmodule
